// file: rtl/adcrb_bank.sv
/*
  Converter register bank behind an APB slave: gain calibration, input
  selection, interrupt control, conversion result and reference control.
  Assumes conversions arrive as a one-cycle conv_done pulse with conv_data,
  and that all inputs are synchronous to sys_clk.
*/
// Design decision made here: register access over APB.
// Notes on behaviour
// - Three writable gain bytes form a 24-bit word driving gain correction.
// - Gain bytes reset to 5Ah, ECh and 5Fh.
// - Upper select nibble picks positive input: 0-7 inputs, 8 common, 15 temperature.
// - Lower select nibble picks negative input with the same codes.
// - Temperature sensor routed only when the whole select register is FFh.
// - Interrupt-control bit 7 doubles the second serial port baud rate.
// - Bit 5 enables the auxiliary interrupt; off means no request.
// - Auxiliary flag stays set and keeps requesting until software clears it.
// - Software writing 1 to auxiliary flag raises a request if enabled.
// - Software writing 1 to watchdog flag raises a request; sticky until cleared.
// - Watchdog interrupt only when watchdog reset action is disabled.
// - Result is 24 bits in three read-only bytes, MSB in high byte bit 7.
// - Reading result low clears converter source; software also clears aux flag.
// - Control bit 6 switches on burnout current sources.
// - Control bit 5 enables the internal reference, on after reset.
// - Control bit 4 selects reference 2.5V (1) or 1.25V (0), default 2.5V.
`timescale 1ns/1ps
`default_nettype none
module adcrb_bank
  import adcrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done,
  input wire logic [23:0] conv_data,
  input wire logic [7:0] aux_source_other,
  input wire logic wdt_timeout,
  output logic [23:0] gain_correction,
  output logic [3:0] positive_input_code,
  output logic [3:0] negative_input_code,
  output logic [8:0] positive_select,
  output logic [8:0] negative_select,
  output logic temp_sensor_enable,
  output logic second_port_baud_double,
  output logic aux_interrupt_request,
  output logic watchdog_interrupt_request,
  output logic watchdog_reset_request,
  output logic burnout_current_enable,
  output logic internal_reference_enable,
  output logic reference_level_select
);

  typedef struct packed {
    logic [7:0] gain_cal_low;
    logic [7:0] gain_cal_mid;
    logic [7:0] gain_cal_high;
    logic [7:0] input_select;
    logic [7:0] interrupt_control;
    logic [7:0] result_low;
    logic [7:0] result_mid;
    logic [7:0] result_high;
    logic [7:0] converter_control_0;
    logic wdt_reset_enable;
    logic conv_source;
    logic rd_wait;
    logic [31:0] rdata;
  } adcrb_state_type;

  adcrb_state_type state;
  adcrb_state_type next_state;

  logic [9:0] word_index;
  logic access;
  logic wr;
  logic rd;
  logic rd_first;
  logic mapped;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic aux_source_any;

  always_comb
  begin
    word_index = paddr[11:2];
    access = psel && penable;
    wr = access && pwrite && pstrb[0];
    rd = access && !pwrite;
    rd_first = rd && !state.rd_wait;
    wbyte = pwdata[7:0];
    aux_source_any = state.conv_source || (|aux_source_other);
    mapped = 1'b1;
    case (word_index)
      {2'b00, IDX_GAIN_CAL_LOW}: rbyte = state.gain_cal_low;
      {2'b00, IDX_GAIN_CAL_MID}: rbyte = state.gain_cal_mid;
      {2'b00, IDX_GAIN_CAL_HIGH}: rbyte = state.gain_cal_high;
      {2'b00, IDX_INPUT_SELECT}: rbyte = state.input_select;
      {2'b00, IDX_INTERRUPT_CONTROL}: rbyte = state.interrupt_control;
      {2'b00, IDX_RESULT_LOW}: rbyte = state.result_low;
      {2'b00, IDX_RESULT_MID}: rbyte = state.result_mid;
      {2'b00, IDX_RESULT_HIGH}: rbyte = state.result_high;
      {2'b00, IDX_CONVERTER_CONTROL_0}: rbyte = state.converter_control_0;
      {2'b00, IDX_HARDWARE_CONFIG}: rbyte = {7'h00, state.wdt_reset_enable};
      default:
      begin
        rbyte = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_state.rdata = APB_ZERO;
    next_state.rd_wait = rd_first;
    // Read data is captured here so prdata leaves a flip-flop, at the cost of one wait state
    if (rd_first && mapped)
    begin
      next_state.rdata = {24'h000000, rbyte};
    end
    if (wr)
    begin
      case (word_index)
        {2'b00, IDX_GAIN_CAL_LOW}: next_state.gain_cal_low = wbyte;
        {2'b00, IDX_GAIN_CAL_MID}: next_state.gain_cal_mid = wbyte;
        {2'b00, IDX_GAIN_CAL_HIGH}: next_state.gain_cal_high = wbyte;
        {2'b00, IDX_INPUT_SELECT}: next_state.input_select = wbyte;
        // Fixed bits are re-forced so a write can never disturb them
        {2'b00, IDX_INTERRUPT_CONTROL}: next_state.interrupt_control = (wbyte & IC_WRITABLE) | IC_FIXED_ONES;
        {2'b00, IDX_CONVERTER_CONTROL_0}: next_state.converter_control_0 = wbyte & CC0_WRITABLE;
        {2'b00, IDX_HARDWARE_CONFIG}: next_state.wdt_reset_enable = wbyte[BIT_WDT_RESET_ENABLE];
        default:
        begin
        end
      endcase
    end
    // Reading the low result byte retires the converter source
    if (rd_first && word_index == {2'b00, IDX_RESULT_LOW})
    begin
      next_state.conv_source = 1'b0;
    end
    // Hardware set wins over a same-cycle software clear
    if (conv_done)
    begin
      next_state.result_low = conv_data[7:0];
      next_state.result_mid = conv_data[15:8];
      next_state.result_high = conv_data[23:16];
      next_state.conv_source = 1'b1;
    end
    if (aux_source_any)
    begin
      next_state.interrupt_control[BIT_AUX_FLAG] = 1'b1;
    end
    if (wdt_timeout && !state.wdt_reset_enable)
    begin
      next_state.interrupt_control[BIT_WDT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state.gain_cal_low <= RST_GAIN_CAL_LOW;
      state.gain_cal_mid <= RST_GAIN_CAL_MID;
      state.gain_cal_high <= RST_GAIN_CAL_HIGH;
      state.input_select <= RST_INPUT_SELECT;
      state.interrupt_control <= RST_INTERRUPT_CONTROL;
      state.result_low <= RST_RESULT;
      state.result_mid <= RST_RESULT;
      state.result_high <= RST_RESULT;
      state.converter_control_0 <= RST_CONVERTER_CONTROL_0;
      state.wdt_reset_enable <= RST_WDT_RESET_ENABLE;
      state.conv_source <= 1'b0;
      state.rd_wait <= 1'b0;
      state.rdata <= APB_ZERO;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Writes complete in their first access cycle, reads in their second
  always_comb
  begin
    pready = !rd_first;
    pslverr = access && !mapped && !rd_first;
    prdata = state.rdata;
  end

  always_comb
  begin
    gain_correction = {state.gain_cal_high, state.gain_cal_mid, state.gain_cal_low};
    positive_input_code = state.input_select[7:4];
    negative_input_code = state.input_select[3:0];
    temp_sensor_enable = (state.input_select == SEL_BOTH_TEMP);
    positive_select = 9'h000;
    negative_select = 9'h000;
    // One-hot: bits 7-0 analog inputs, bit 8 common input
    if (!positive_input_code[3])
    begin
      positive_select[positive_input_code[2:0]] = 1'b1;
    end
    else if (positive_input_code == SEL_COMMON)
    begin
      positive_select[8] = 1'b1;
    end
    if (!negative_input_code[3])
    begin
      negative_select[negative_input_code[2:0]] = 1'b1;
    end
    else if (negative_input_code == SEL_COMMON)
    begin
      negative_select[8] = 1'b1;
    end
    second_port_baud_double = state.interrupt_control[BIT_BAUD_DOUBLE];
    aux_interrupt_request = state.interrupt_control[BIT_AUX_ENABLE]
                            && state.interrupt_control[BIT_AUX_FLAG];
    watchdog_interrupt_request = state.interrupt_control[BIT_WDT_FLAG]
                                 && !state.wdt_reset_enable;
    watchdog_reset_request = wdt_timeout && state.wdt_reset_enable;
    burnout_current_enable = state.converter_control_0[BIT_BURNOUT];
    internal_reference_enable = state.converter_control_0[BIT_REF_ENABLE];
    reference_level_select = state.converter_control_0[BIT_REF_LEVEL];
  end

endmodule // adcrb_bank
`default_nettype wire

// file: rtl/adcrb_pkg.sv
/*
  Package for the converter register bank: register offsets, field positions,
  reset values and input-selection codes.
  Assumes a 32-bit APB master; each 8-bit register sits in the low byte of one word.
*/
package adcrb_pkg;
  // Printed offsets are not multiples of four: they are word indices
  localparam logic [7:0] IDX_GAIN_CAL_LOW = 8'hD4;
  localparam logic [7:0] IDX_GAIN_CAL_MID = 8'hD5;
  localparam logic [7:0] IDX_GAIN_CAL_HIGH = 8'hD6;
  localparam logic [7:0] IDX_INPUT_SELECT = 8'hD7;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'hD8;
  localparam logic [7:0] IDX_RESULT_LOW = 8'hD9;
  localparam logic [7:0] IDX_RESULT_MID = 8'hDA;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'hDB;
  localparam logic [7:0] IDX_CONVERTER_CONTROL_0 = 8'hDC;
  localparam logic [7:0] IDX_HARDWARE_CONFIG = 8'hE8;

  localparam logic [7:0] RST_GAIN_CAL_LOW = 8'h5A;
  localparam logic [7:0] RST_GAIN_CAL_MID = 8'hEC;
  localparam logic [7:0] RST_GAIN_CAL_HIGH = 8'h5F;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h40;
  localparam logic [7:0] RST_CONVERTER_CONTROL_0 = 8'h30;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic RST_WDT_RESET_ENABLE = 1'h1;

  // interrupt_control fields
  localparam int BIT_BAUD_DOUBLE = 7;
  localparam int BIT_AUX_ENABLE = 5;
  localparam int BIT_AUX_FLAG = 4;
  localparam int BIT_WDT_FLAG = 3;
  localparam logic [7:0] IC_FIXED_ONES = 8'h40;
  localparam logic [7:0] IC_WRITABLE = 8'hB8;

  // converter_control_0 fields
  localparam int BIT_BURNOUT = 6;
  localparam int BIT_REF_ENABLE = 5;
  localparam int BIT_REF_LEVEL = 4;
  localparam logic [7:0] CC0_WRITABLE = 8'h7F;

  // hardware_config_reg field
  localparam int BIT_WDT_RESET_ENABLE = 0;

  localparam logic [3:0] SEL_COMMON = 4'h8;
  localparam logic [3:0] SEL_TEMP = 4'hF;
  localparam logic [7:0] SEL_BOTH_TEMP = 8'hFF;

  localparam logic [31:0] APB_ZERO = 32'h0000_0000;
endpackage : adcrb_pkg

// file: sim/adcrb_sva.sv
/*
  Checker for the converter register bank: write effects, sticky request, fixed read bits.
  Assumes it is bound to adcrb_bank and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module adcrb_sva
  import adcrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [23:0] gain_correction,
  input wire logic [3:0] positive_input_code,
  input wire logic [3:0] negative_input_code,
  input wire logic temp_sensor_enable,
  input wire logic second_port_baud_double,
  input wire logic aux_interrupt_request,
  input wire logic burnout_current_enable,
  input wire logic internal_reference_enable,
  input wire logic reference_level_select
);
  logic wr;
  logic [7:0] ix;
  // Upper address bits must be zero, else the access is unmapped
  assign wr = psel && penable && pready && pwrite && pstrb[0] && paddr[11:10] == 2'h0;
  assign ix = paddr[9:2];
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_wr_ic; wr && ix == IDX_INTERRUPT_CONTROL; endsequence
  sequence s_rd_ic; psel && penable && pready && !pwrite && paddr[11:10] == 2'h0 && ix == IDX_INTERRUPT_CONTROL;
  endsequence
  property p_gain; wr && ix == IDX_GAIN_CAL_LOW |=> gain_correction[7:0] == $past(pwdata[7:0]); endproperty
  a_gain: assert property (p_gain) else $error("gain low byte not applied");
  property p_sel; wr && ix == IDX_INPUT_SELECT |=> {positive_input_code, negative_input_code} == $past(pwdata[7:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("input codes not applied");
  property p_temp; temp_sensor_enable == (positive_input_code == SEL_TEMP && negative_input_code == SEL_TEMP); endproperty
  a_temp: assert property (p_temp) else $error("temperature routing wrong");
  property p_baud; s_wr_ic |=> second_port_baud_double == $past(pwdata[7]); endproperty
  a_baud: assert property (p_baud) else $error("baud doubling not applied");
  property p_aux_off; s_wr_ic ##0 !pwdata[5] |=> !aux_interrupt_request; endproperty
  a_aux_off: assert property (p_aux_off) else $error("request while disabled");
  property p_aux_hold; aux_interrupt_request && !(wr && ix == IDX_INTERRUPT_CONTROL) |=> aux_interrupt_request; endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("request dropped without clear");
  property p_ic_read; s_rd_ic |-> prdata[6] && prdata[2:0] == 3'h0; endproperty
  a_ic_read: assert property (p_ic_read) else $error("fixed control bits wrong");
  property p_cc0; wr && ix == IDX_CONVERTER_CONTROL_0 |=>
    {burnout_current_enable, internal_reference_enable, reference_level_select} == $past(pwdata[6:4]); endproperty
  a_cc0: assert property (p_cc0) else $error("converter control not applied");
endmodule // adcrb_sva
bind adcrb_bank adcrb_sva u_sva (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .gain_correction(gain_correction),
  .positive_input_code(positive_input_code), .negative_input_code(negative_input_code),
  .temp_sensor_enable(temp_sensor_enable), .second_port_baud_double(second_port_baud_double),
  .aux_interrupt_request(aux_interrupt_request), .burnout_current_enable(burnout_current_enable),
  .internal_reference_enable(internal_reference_enable), .reference_level_select(reference_level_select));
`default_nettype wire

// file: sim/testbench.sv
/*
  Self-checking bench for the converter register bank, acting as APB master.
  Assumes the bound checker; transfers wait on pready, so no wait-state count is assumed.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import adcrb_pkg::*;
;
  logic sys_clk, rst, psel, penable, pwrite, conv_done, wdt_timeout, err;
  logic pready, pslverr, temp_sensor_enable, second_port_baud_double, aux_interrupt_request;
  logic watchdog_interrupt_request, watchdog_reset_request, burnout_current_enable;
  logic internal_reference_enable, reference_level_select;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, sd;
  logic [3:0] pstrb, strb, positive_input_code, negative_input_code;
  logic [23:0] conv_data, gain_correction, x;
  logic [8:0] positive_select, negative_select;
  logic [7:0] aux_source_other, rd, d;
  int n_mismatch, n_tests, cyc;
  logic [7:0] rst_tab [9] = '{8'h5A, 8'hEC, 8'h5F, 8'h01, 8'h40, 8'h00, 8'h00, 8'h00, 8'h30};
  adcrb_bank u_dut (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] adr(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  function automatic logic [8:0] sel_exp(input logic [3:0] c);
    return (c < 4'h9) ? 9'h001 << c : 9'h000;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Ends at the falling edge so register effects have settled before any check
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, v};
    pstrb <= strb;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, conv_done, wdt_timeout} = 5'h00;
    {paddr, pwdata, conv_data, aux_source_other} = '0;
    strb = 4'hF;
    pstrb = 4'hF;
    sd = 32'hECCD;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, adr(IDX_GAIN_CAL_LOW + 8'(i)), 8'h00);
      chk(rd, rst_tab[i]);
    end
    sd = lfsr(sd);
    x = sd[23:0];
    for (int i = 0; i < 3; i++)
      apb(1'b1, adr(IDX_GAIN_CAL_LOW + 8'(i)), x[8*i +: 8]);
    chk(gain_correction, x);
    strb = 4'hE;
    apb(1'b1, adr(IDX_GAIN_CAL_LOW), ~x[7:0]);
    strb = 4'hF;
    chk(gain_correction, x);
    apb(1'b1, adr(IDX_RESULT_LOW), 8'hFF);
    apb(1'b0, adr(IDX_RESULT_LOW), 8'h00);
    chk(rd, 8'h00);
    apb(1'b0, 12'h000, 8'h00);
    chk({err, rd}, 9'h100);
    for (int c = 0; c < 16; c++)
    begin
      d = {4'(c), 4'(15 - c)};
      apb(1'b1, adr(IDX_INPUT_SELECT), d);
      chk({positive_select, negative_select}, {sel_exp(d[7:4]), sel_exp(d[3:0])});
      chk({positive_input_code, negative_input_code}, d);
      chk(temp_sensor_enable, 1'b0);
    end
    apb(1'b1, adr(IDX_INPUT_SELECT), 8'hFF);
    chk({temp_sensor_enable, positive_select}, 10'h200);
    for (int i = 0; i < 6; i++)
    begin
      sd = lfsr(sd);
      d = (i < 4) ? 8'(32'hFF102700 >> (8 * i)) : sd[7:0];
      apb(1'b1, adr(IDX_INTERRUPT_CONTROL), d);
      apb(1'b0, adr(IDX_INTERRUPT_CONTROL), 8'h00);
      chk(rd, (d & 8'hB8) | 8'h40);
      chk({second_port_baud_double, aux_interrupt_request, watchdog_interrupt_request}, {d[7], d[5] & d[4], 1'b0});
    end
    apb(1'b1, adr(IDX_HARDWARE_CONFIG), 8'h00);
    apb(1'b1, adr(IDX_INTERRUPT_CONTROL), 8'h08);
    apb(1'b0, adr(IDX_GAIN_CAL_MID), 8'h00);
    chk(watchdog_interrupt_request, 1'b1);
    apb(1'b1, adr(IDX_HARDWARE_CONFIG), 8'h01);
    chk(watchdog_interrupt_request, 1'b0);
    @(posedge sys_clk);
    wdt_timeout <= 1'b1;
    @(negedge sys_clk);
    chk(watchdog_reset_request, 1'b1);
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    // With the reset action off, the flag still set by the earlier write requests again, and a timeout asks for no reset
    apb(1'b1, adr(IDX_HARDWARE_CONFIG), 8'h00);
    @(posedge sys_clk);
    wdt_timeout <= 1'b1;
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    @(negedge sys_clk);
    chk({watchdog_reset_request, watchdog_interrupt_request}, 2'h1);
    apb(1'b1, adr(IDX_INTERRUPT_CONTROL), 8'h00);
    sd = lfsr(sd);
    @(posedge sys_clk);
    conv_done <= 1'b1;
    conv_data <= sd[23:0];
    @(posedge sys_clk);
    conv_done <= 1'b0;
    // Source still pending, so clearing the flag must not stick
    apb(1'b1, adr(IDX_INTERRUPT_CONTROL), 8'h20);
    chk(aux_interrupt_request, 1'b1);
    for (int i = 2; i >= 0; i--)
    begin
      apb(1'b0, adr(IDX_RESULT_LOW + 8'(i)), 8'h00);
      chk(rd, sd[8*i +: 8]);
    end
    apb(1'b1, adr(IDX_INTERRUPT_CONTROL), 8'h20);
    chk(aux_interrupt_request, 1'b0);
    @(posedge sys_clk);
    aux_source_other <= sd[7:0] | 8'h01;
    @(posedge sys_clk);
    aux_source_other <= 8'h00;
    apb(1'b0, adr(IDX_GAIN_CAL_MID), 8'h00);
    chk(aux_interrupt_request, 1'b1);
    apb(1'b1, adr(IDX_INTERRUPT_CONTROL), 8'h10);
    chk(aux_interrupt_request, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      sd = lfsr(sd);
      d = (i < 2) ? 8'(16'hC03F >> (8 * i)) : sd[7:0];
      apb(1'b1, adr(IDX_CONVERTER_CONTROL_0), d);
      apb(1'b0, adr(IDX_CONVERTER_CONTROL_0), 8'h00);
      chk(rd, d & 8'h7F);
      chk({burnout_current_enable, internal_reference_enable, reference_level_select}, d[6:4]);
    end
    test_done;
  end
endmodule // testbench
`default_nettype wire
